//--- hdl/conv_host_pkg.sv
// shared constants and state type of the converter host glue
package conv_host_pkg;

  localparam int CLK_NS         = 50;   // 20 MHz core clock
  localparam int T_WR_NS        = 125;  // write strobe stretch length
  localparam int T_RD_NS        = 100;  // least read strobe width
  localparam int T_ST_NS        = 200;  // start pulse, covers acquisition
  localparam int T_CONV_MAX_NS  = 4000; // longest wait for completion
  localparam int SYNC_LAT       = 4;    // pin to stable value, in cycles
  localparam int DATA_W         = 8;
  localparam int CNT_W          = 8;
  localparam int SAMP_W         = 16;
  localparam int SAMPLE_CYC_DEF = 49;   // about 408.2 kHz sample rate
  localparam int STORE_AW_DEF   = 4;

  // least time: round up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // longest time: round down, never below one
  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WR_CYC       = cyc_up(T_WR_NS);
  localparam int RD_CYC       = cyc_up(T_RD_NS);
  localparam int ST_CYC       = cyc_up(T_ST_NS);
  localparam int CONV_MAX_CYC = cyc_dn(T_CONV_MAX_NS);
  localparam int FETCH_CYC    = RD_CYC + SYNC_LAT;

  localparam logic [CNT_W-1:0]  WR_END    = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0]  FETCH_END = CNT_W'(FETCH_CYC - 1);
  localparam logic [CNT_W-1:0]  CONV_END  = CNT_W'(CONV_MAX_CYC - 1);
  localparam logic [CNT_W-1:0]  SYNC_END  = CNT_W'(SYNC_LAT - 1);
  localparam logic [SAMP_W-1:0] ST_LEN    = SAMP_W'(ST_CYC);

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_WRITE  = 7'h02,
    S_WREC   = 7'h04,
    S_READ   = 7'h08,
    S_CONV   = 7'h10,
    S_SETTLE = 7'h20,
    S_REL    = 7'h40
  } glue_state_e;

endpackage

//--- hdl/store_if.sv
// carrier between the glue and its result store
`timescale 1ns/1ps
interface store_if #(parameter int W = 8);
  logic         push;
  logic [W-1:0] push_data;
  logic         pop;
  logic         full;
  logic         empty;
  logic [W-1:0] rd_data;
  logic         rd_valid;
  modport writer (output push, push_data, pop,
                  input  full, empty, rd_data, rd_valid);
  modport store  (input  push, push_data, pop,
                  output full, empty, rd_data, rd_valid);
endinterface

//--- hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] stable_out
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1         <= RST_VAL;
      s2         <= RST_VAL;
      s3         <= RST_VAL;
      stable_out <= RST_VAL;
    end else begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        stable_out <= s3;
      end
    end
  end

endmodule

//--- hdl/result_store.sv
// small result buffer memory with registered read data
`timescale 1ns/1ps
module result_store #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  store_if.store    bus
);

  localparam int DEPTH = 1 << AW;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   count;

  // a push into a full store is dropped; the writer flags it
  wire          do_push    = bus.push && !bus.full;
  wire          do_pop     = bus.pop && !bus.empty;
  wire [AW:0]   next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);

  // storage has no reset; pointers, count, flags and read register do
  always_ff @(posedge core_clk_in) begin
    if (do_push) begin
      mem[wp] <= bus.push_data;
    end
  end

  // pointers, level flags and the read register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp           <= '0;
      rp           <= '0;
      count        <= '0;
      bus.full     <= 1'b0;
      bus.empty    <= 1'b1;
      bus.rd_data  <= '0;
      bus.rd_valid <= 1'b0;
    end else begin
      count        <= next_count;
      bus.full     <= (next_count == (AW+1)'(DEPTH));
      bus.empty    <= (next_count == '0);
      bus.rd_valid <= do_pop;
      if (do_push) begin
        wp <= wp + 1'b1;
      end
      if (do_pop) begin
        rp          <= rp + 1'b1;
        bus.rd_data <= mem[rp];
      end
    end
  end

endmodule

//--- hdl/converter_host_bus_glue.sv
// host-side bus glue driving an 8-bit converter through its pins
//
// Notes on behaviour
// - timer, not software, paces start pulses
// - mode 1: fetch result after completion
// - dac load is one write cycle
// - mode 2: one read converts and returns
// - halt host read until completion
// - writes acknowledged promptly, no waits
// - halt only on reads, never writes
// - write strobe stretched, width sets length
// - completion low: read pulse, capture result
// - read pulse rise raises interrupt
// - buffer results between converter and host
// - mode 2: start input held high
`timescale 1ns/1ps
module converter_host_bus_glue
  import conv_host_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYC_DEF,
  parameter int STORE_AW   = STORE_AW_DEF
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              mode2_in,
  input  wire logic              sample_en_in,
  input  wire logic              cmd_valid_in,
  input  wire logic              cmd_write_in,
  input  wire logic              cmd_dac_b_in,
  input  wire logic [DATA_W-1:0] cmd_data_in,
  output logic                   cmd_ready_out,
  output logic                   write_ack_out,
  output logic                   wait_out,
  output logic [DATA_W-1:0]      result_data_out,
  output logic                   result_strobe_out,
  output logic                   irq_out,
  output logic                   conv_error_out,
  output logic                   overrun_out,
  output logic                   conv_busy_out,
  input  wire logic              fifo_pop_in,
  output logic [DATA_W-1:0]      fifo_data_out,
  output logic                   fifo_valid_out,
  output logic                   fifo_empty_out,
  output logic                   fifo_full_out,
  output logic                   cs_n_out,
  output logic                   rd_n_out,
  output logic                   wr_n_out,
  output logic                   dac_b_out,
  output logic                   start_convert_n_out,
  output logic [DATA_W-1:0]      bus_data_out,
  output logic                   bus_oe_out,
  input  wire logic [DATA_W-1:0] bus_data_in,
  input  wire logic              int_n_in,
  input  wire logic              busy_n_in
);

  localparam logic [SAMP_W-1:0] SAMPLE_END = SAMP_W'(SAMPLE_CYC - 1);

  glue_state_e       state;
  glue_state_e       next_state;
  logic [CNT_W-1:0]  cnt;
  logic [SAMP_W-1:0] samp_cnt;
  logic              auto;
  logic [DATA_W-1:0] data_s;
  logic              int_s;
  logic              busy_s;

  store_if #(.W(DATA_W)) bif ();

  ////////////////////////////////////////////////////////////////////////
  // pin inputs and result store

  // data, completion and busy all cross in from the converter
  pin_sync #(
    .W       (DATA_W + 2),
    .RST_VAL ({(DATA_W + 2){1'b1}})
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .raw_in      ({busy_n_in, int_n_in, bus_data_in}),
    .stable_out  ({busy_s, int_s, data_s})
  );

  result_store #(
    .W  (DATA_W),
    .AW (STORE_AW)
  ) u_store (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .bus         (bif)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode

  // the converter pulls completion low when a conversion ends
  wire int_low  = !int_s;
  wire take     = cmd_valid_in && cmd_ready_out;
  wire take_wr  = take && cmd_write_in;
  wire take_rd  = take && !cmd_write_in;
  // a host command wins; the completion level simply waits for it
  wire auto_go  = !mode2_in && int_low && !take;
  wire wr_end   = (state == S_WRITE) && (cnt == WR_END);
  wire rd_end   = (state == S_READ) && (cnt == FETCH_END);
  wire conv_to  = (state == S_CONV) && (cnt == CONV_END);
  wire set_end  = (state == S_SETTLE) && (cnt == SYNC_END);
  wire rel_to   = (state == S_REL) && (cnt == CONV_END);
  wire cap      = rd_end || set_end || conv_to;
  wire push_w   = cap && auto;
  wire timer_on = sample_en_in && !mode2_in;

  // pin levels for the coming cycle, registered below
  wire n_read   = (next_state == S_READ) || (next_state == S_CONV) ||
                  (next_state == S_SETTLE);
  wire n_write  = (next_state == S_WRITE);
  wire n_wrec   = (next_state == S_WREC);
  wire n_halt   = (next_state == S_CONV) || (next_state == S_SETTLE);

  assign bif.push      = push_w;
  assign bif.push_data = data_s;
  assign bif.pop       = fifo_pop_in;
  assign fifo_data_out  = bif.rd_data;
  assign fifo_valid_out = bif.rd_valid;
  assign fifo_empty_out = bif.empty;
  assign fifo_full_out  = bif.full;

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  // next state of the bus cycle sequencer
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (take_wr) begin
          next_state = S_WRITE;
        end else if (take_rd && mode2_in) begin
          next_state = S_CONV;
        end else if (take_rd || auto_go) begin
          next_state = S_READ;
        end
      end
      S_WRITE: begin
        if (wr_end) begin
          next_state = S_WREC;
        end
      end
      S_WREC: begin
        next_state = S_IDLE;
      end
      S_READ: begin
        if (rd_end) begin
          next_state = S_REL;
        end
      end
      S_CONV: begin
        // read stays pending until completion, with a bound
        if (int_low) begin
          next_state = S_SETTLE;
        end else if (conv_to) begin
          next_state = S_REL;
        end
      end
      S_SETTLE: begin
        if (set_end) begin
          next_state = S_REL;
        end
      end
      S_REL: begin
        // completion goes high again on the read rise
        if (int_s || rel_to) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // state and the per-state cycle counter
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= S_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= (next_state != state) ? '0 : cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter pins

  // strobes are flops so the pins never glitch on decode
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_n_out   <= 1'b1;
      rd_n_out   <= 1'b1;
      wr_n_out   <= 1'b1;
      bus_oe_out <= 1'b0;
      wait_out   <= 1'b0;
    end else begin
      cs_n_out   <= !(n_read || n_write || n_wrec);
      rd_n_out   <= !n_read;
      wr_n_out   <= !n_write;
      bus_oe_out <= n_write || n_wrec;
      wait_out   <= n_halt;
    end
  end

  // write data and dac select held from take until the next write
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_data_out <= 8'h00;
      dac_b_out    <= 1'b0;
    end else if (take_wr) begin
      bus_data_out <= cmd_data_in;
      dac_b_out    <= cmd_dac_b_in;
    end
  end

  // free-running sample timer; mode 2 keeps the start input high
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      samp_cnt            <= '0;
      start_convert_n_out <= 1'b1;
    end else begin
      if (!timer_on || samp_cnt == SAMPLE_END) begin
        samp_cnt <= '0;
      end else begin
        samp_cnt <= samp_cnt + 1'b1;
      end
      start_convert_n_out <= !(timer_on && samp_cnt < ST_LEN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // results and status

  // auto marks a fetch started by completion, not by a command
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      auto <= 1'b0;
    end else if (state == S_IDLE) begin
      auto <= auto_go;
    end
  end

  // capture at the read rise; interrupt only for completion fetches
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_data_out   <= 8'h00;
      result_strobe_out <= 1'b0;
      irq_out           <= 1'b0;
      write_ack_out     <= 1'b0;
      cmd_ready_out     <= 1'b0;
      conv_busy_out     <= 1'b0;
    end else begin
      if (cap) begin
        result_data_out <= data_s;
      end
      result_strobe_out <= cap;
      irq_out           <= push_w;
      write_ack_out     <= n_wrec;
      cmd_ready_out     <= (next_state == S_IDLE);
      conv_busy_out     <= !busy_s;
    end
  end

  // sticky error flags; a new event wins over the clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_error_out <= 1'b0;
      overrun_out    <= 1'b0;
    end else begin
      if (conv_to) begin
        conv_error_out <= 1'b1;
      end else if (take_rd) begin
        conv_error_out <= 1'b0;
      end
      if (push_w && bif.full) begin
        overrun_out <= 1'b1;
      end else if (fifo_pop_in) begin
        overrun_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // helper: cycles since the last start pulse while the timer ran
  logic [SAMP_W-1:0] gap;
  logic              gap_run;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap     <= '0;
      gap_run <= 1'b0;
    end else if (!timer_on) begin
      gap_run <= 1'b0;
    end else if (start_convert_n_out == 1'b0 && gap_run == 1'b0) begin
      gap     <= '0;
      gap_run <= 1'b1;
    end else begin
      gap <= gap + 1'b1;
      if (!start_convert_n_out && gap == SAMPLE_END) begin
        gap <= '0;
      end
    end
  end

  chk_st_period:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ($fell(start_convert_n_out) && $past(gap_run) && timer_on)
        |-> $past(gap) == SAMPLE_END - 1'b1)
    else $error("start pulses not evenly spaced");

  chk_fetch_after_int:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ($fell(rd_n_out) && auto) |-> $past(int_low) && !$past(mode2_in))
    else $error("result fetched without completion");

  chk_write_frame:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(wr_n_out) |-> bus_oe_out && !cs_n_out && $stable(bus_data_out))
    else $error("write data not held at strobe rise");

  chk_read_halt:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      wait_out |-> !rd_n_out && !cs_n_out && start_convert_n_out)
    else $error("halt without a pending read");

  chk_halt_hold:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state == S_CONV && int_s && !conv_to) |=> wait_out)
    else $error("host released before completion");

  chk_ack_prompt:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      write_ack_out |-> !wait_out && $past(!wr_n_out) && wr_n_out)
    else $error("write ack not at strobe end");

  chk_halt_reads_only:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      wait_out |-> wr_n_out && !bus_oe_out)
    else $error("host halted on a write");

  chk_write_stretch:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $fell(wr_n_out) |-> !wr_n_out [*3] ##1 (wr_n_out && write_ack_out))
    else $error("write strobe width wrong");

  chk_capture_value:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      result_strobe_out |-> result_data_out == $past(data_s) && rd_n_out)
    else $error("captured result mismatch");

  chk_irq_on_rise:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ($rose(rd_n_out) && auto) |-> irq_out && result_strobe_out)
    else $error("no interrupt at read rise");

  chk_buffer_push:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (irq_out && $past(!bif.full)) |-> !fifo_empty_out)
    else $error("fetched result not buffered");

  chk_st_mode2:
    assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      mode2_in |=> start_convert_n_out)
    else $error("start pulsed in mode 2");

endmodule

//--- verification/conv_model.sv
// behavioural pin model of the converter: conversions, completion, dacs
`timescale 1ns/1ps
module conv_model #(
  parameter int CONV_NS = 800,
  parameter int SLOW_NS = 6000
) (
  input  wire logic       cs_n_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic       dac_b_in,
  input  wire logic       start_convert_n_in,
  input  wire logic       mode2_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] sample_in,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] data_out,
  output logic            int_n_out,
  output logic            busy_n_out,
  output logic [1:0][7:0] dac_reg_out
);
  logic [7:0] result;
  logic       rd_seen;

  initial begin
    result = 8'h00;
    rd_seen = 1'b0;
    int_n_out = 1'b1;
    busy_n_out = 1'b1;
    dac_reg_out = '0;
  end

  // one conversion; the input is frozen when it starts
  task automatic convert();
    logic [7:0] held;
    held = sample_in;
    busy_n_out = 1'b0;
    #(slow_in ? SLOW_NS : CONV_NS);
    result = held;
    busy_n_out = 1'b1;
    int_n_out = 1'b0;
  endtask

  // timer start in mode 1, read start in mode 2; restarts while busy ignored
  always @(negedge start_convert_n_in)
    if (!mode2_in && busy_n_out)
      convert();
  // both strobes watched, so their order within one edge does not matter
  always @(negedge rd_n_in or negedge cs_n_in)
    if (mode2_in && !cs_n_in && !rd_n_in && busy_n_out)
      convert();

  // completion clears on the rise of either strobe of a result read
  always @(negedge rd_n_in or negedge cs_n_in)
    if (!cs_n_in && !rd_n_in)
      rd_seen = 1'b1;
  always @(posedge rd_n_in or posedge cs_n_in)
    if (rd_seen) begin
      rd_seen = 1'b0;
      int_n_out = 1'b1;
    end

  // released bus shows the inverse so a stale value can never match
  assign data_out = (!cs_n_in && !rd_n_in) ? result : ~result;

  // dac register loads on the write strobe rise
  always @(posedge wr_n_in)
    if (!cs_n_in)
      dac_reg_out[dac_b_in] = bus_in;
endmodule

//--- verification/converter_host_bus_glue_test.sv
// self-checking bench for the converter host glue against a pin model
`timescale 1ns/1ps
module converter_host_bus_glue_test;
  import conv_host_pkg::*;
  localparam int SAMP  = 40;    // timer period, cycles
  localparam int LIMIT = 20000; // hang guard, cycles
  logic              core_clk_in, rst_n_in, mode2_in, sample_en_in, slow;
  logic              cmd_valid_in, cmd_write_in, cmd_dac_b_in, fifo_pop_in;
  logic [DATA_W-1:0] cmd_data_in, sample, last_res;
  logic              cmd_ready_out, write_ack_out, wait_out, irq_out;
  logic              result_strobe_out, conv_error_out, overrun_out;
  logic              conv_busy_out, fifo_valid_out, fifo_empty_out;
  logic              fifo_full_out, cs_n_out, rd_n_out, wr_n_out, dac_b_out;
  logic              start_convert_n_out, bus_oe_out, int_n_in, busy_n_in;
  logic [DATA_W-1:0] result_data_out, fifo_data_out, bus_data_out, dev_data;
  logic [1:0][7:0]   dac_reg;
  wire  [DATA_W-1:0] bus_data_in;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] fifo_q[$];
  int                miscompares = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                st_fall = 0;
  int                n_irq = 0;

  // wire level of the shared data bus
  assign bus_data_in = bus_oe_out ? bus_data_out : dev_data;

  converter_host_bus_glue #(.SAMPLE_CYC(SAMP)) dut (
    .core_clk_in, .rst_n_in, .mode2_in, .sample_en_in, .cmd_valid_in,
    .cmd_write_in, .cmd_dac_b_in, .cmd_data_in, .cmd_ready_out,
    .write_ack_out, .wait_out, .result_data_out, .result_strobe_out,
    .irq_out, .conv_error_out, .overrun_out, .conv_busy_out, .fifo_pop_in,
    .fifo_data_out, .fifo_valid_out, .fifo_empty_out, .fifo_full_out,
    .cs_n_out, .rd_n_out, .wr_n_out, .dac_b_out, .start_convert_n_out,
    .bus_data_out, .bus_oe_out, .bus_data_in, .int_n_in, .busy_n_in
  );

  conv_model model (
    .cs_n_in(cs_n_out),
    .rd_n_in(rd_n_out),
    .wr_n_in(wr_n_out),
    .dac_b_in(dac_b_out),
    .start_convert_n_in(start_convert_n_out),
    .mode2_in(mode2_in),
    .slow_in(slow),
    .sample_in(sample),
    .bus_in(bus_data_in),
    .data_out(dev_data),
    .int_n_out(int_n_in),
    .busy_n_out(busy_n_in),
    .dac_reg_out(dac_reg)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #(CLK_NS / 2) core_clk_in = ~core_clk_in;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // cycle count; a hang ends the run as a mismatch
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      end_of_test();
    end
  end

  // oldest note is taken as each capture or pop shows
  always @(posedge core_clk_in) begin
    if (result_strobe_out === 1'b1) begin
      check("irq", irq_out, !mode2_in);
      if (exp_q.size() == 0)
        check("spare result", 1, 0);
      else
        check("result", result_data_out, exp_q.pop_front());
    end
    if (fifo_valid_out === 1'b1)
      check("fifo", fifo_data_out, fifo_q.pop_front());
    if (irq_out === 1'b1)
      n_irq++;
  end

  // each timer start freezes the sample the model converts
  always @(negedge start_convert_n_out)
    if (rst_n_in === 1'b1) begin
      if (st_fall > 0)
        check("period", cyc - st_fall, SAMP);
      st_fall = cyc;
      last_res = sample;
      exp_q.push_back(sample);
      if (fifo_q.size() < 16)
        fifo_q.push_back(sample);
      #2 sample = 8'($urandom);
    end
  always @(posedge start_convert_n_out)
    if (rst_n_in === 1'b1 && st_fall > 0)
      check("start width", cyc - st_fall, ST_CYC);

  // request held from just after an edge until the edge that takes it
  task automatic issue(input logic wr, input logic b, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    #2;
    cmd_valid_in = 1'b1;
    cmd_write_in = wr;
    cmd_dac_b_in = b;
    cmd_data_in = d;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (cmd_ready_out !== 1'b1 && n < 300);
    #2 cmd_valid_in = 1'b0;
  endtask

  task automatic dac_write(input logic b, input logic [7:0] d);
    issue(1'b1, b, d);
    for (int k = 1; k <= 4; k++) begin
      @(posedge core_clk_in);
      #1;
      check("write ack", write_ack_out, k == 3);
      check("write stretch", wr_n_out, k >= 3);
      check("halt on write", wait_out, 0);
    end
    check("dac reg", dac_reg[b], d);
  endtask

  task automatic conv_read(input logic [7:0] exp);
    int n_wait;
    int n_busy;
    n_wait = 0;
    n_busy = 0;
    exp_q.push_back(exp);
    issue(1'b0, 1'b0, 8'($urandom));
    for (int k = 0; k < 300 && cmd_ready_out !== 1'b1; k++) begin
      @(posedge core_clk_in);
      #1;
      n_wait += (wait_out === 1'b1);
      n_busy += (conv_busy_out === 1'b1);
      check("start held", start_convert_n_out, 1);
    end
    check("host halted", n_wait > 0, 1);
    check("busy seen", n_busy > 0, 1);
    check("timeout flag", conv_error_out, slow);
  endtask

  initial begin
    rst_n_in = 1'b0;
    mode2_in = 1'b1;
    sample_en_in = 1'b0;
    slow = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_write_in = 1'b0;
    cmd_dac_b_in = 1'b0;
    cmd_data_in = 8'h00;
    fifo_pop_in = 1'b0;
    sample = 8'h00;
    last_res = 8'h00;
    void'($urandom(32'h69c3));
    repeat (4) @(posedge core_clk_in);
    check("reset pins", {cs_n_out, rd_n_out, wr_n_out, start_convert_n_out,
          bus_oe_out, cmd_ready_out, fifo_empty_out}, 7'h79);
    #2 rst_n_in = 1'b1;
    // back-to-back loads of both dacs
    for (int i = 0; i < 4; i++)
      dac_write(i[0], 8'($urandom));
    $display("test dac writes done");
    // single-read conversions, each followed at once by a write
    for (int i = 0; i < 3; i++) begin
      sample = 8'($urandom);
      last_res = sample;
      conv_read(sample);
      dac_write(1'b0, ~sample);
    end
    $display("test single read conversions done");
    // timed conversions fill the store past its depth without pops
    @(posedge core_clk_in);
    #2;
    mode2_in = 1'b0;
    sample_en_in = 1'b1;
    for (int k = 0; k < 18 * SAMP + 200 && n_irq < 18; k++)
      @(posedge core_clk_in);
    #2 sample_en_in = 1'b0;
    repeat (SAMP) @(posedge core_clk_in);
    check("store full", fifo_full_out, 1);
    check("overrun", overrun_out, 1);
    check("pending notes", exp_q.size(), 0);
    for (int k = 0; k < 20 && fifo_empty_out !== 1'b1; k++) begin
      @(posedge core_clk_in);
      #2 fifo_pop_in = 1'b1;
      @(posedge core_clk_in);
      #2 fifo_pop_in = 1'b0;
      check("overrun cleared", overrun_out, 0);
    end
    repeat (2) @(posedge core_clk_in);
    check("store drained", fifo_q.size(), 0);
    $display("test timed conversions and store done");
    // conversion too slow: old data returned and the flag set
    @(posedge core_clk_in);
    #2;
    mode2_in = 1'b1;
    slow = 1'b1;
    conv_read(last_res);
    $display("test slow conversion done");
    end_of_test();
  end
endmodule
